//--- logic/vidstp_pkg.sv
package vidstp_pkg;
    localparam int CODE_W = 8;
    localparam int UV_W = 21;
    localparam logic [7:0] CODE_OFF_LO = 8'hFE;
    localparam logic [7:0] CODE_FLOOR = 8'hB2;
    localparam logic [7:0] CODE_BOOT = 8'h52;
    localparam int LSB_UV = 6250;
    localparam int TOP_UV = 1612500;
    localparam int STEP_UV = 12500;
    localparam logic [8:0] STEP_CODES = 9'(STEP_UV / LSB_UV);
    localparam int SAMPLES_PER_CYCLE = 6;

    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic [UV_W-1:0] uv;
    } vidstp_dac_t;

    function automatic logic vidstp_is_off(input logic [CODE_W-1:0] c);
        return c >= CODE_OFF_LO;
    endfunction

    // Codes past the floor are not listed; they clamp to the lowest level.
    function automatic logic [CODE_W-1:0] vidstp_target(input logic [CODE_W-1:0] c);
        return (c > CODE_FLOOR) ? CODE_FLOOR : c;
    endfunction

    function automatic logic [UV_W-1:0] vidstp_uv(input logic [CODE_W-1:0] c);
        return UV_W'(TOP_UV - int'(c) * LSB_UV);
    endfunction
endpackage

//--- logic/vidstp_top.sv
`timescale 1ns/10ps
// Contract
// - The 8-bit code maps to a DAC level falling 6.25mV per code unit down to 0.5V, and codes FE and FF mean OFF.
// - While regulating, the code is sampled six times per switching cycle and compared with the DAC code.
// - A code change of at most one step is qualified by a half-cycle wait and then the DAC moves straight to it.
// - If the DAC-to-code difference changes during the half-cycle wait, the step is dropped and the DAC holds.
// - A code more than one step away is chased with a 12.5mV step on each of the six samples per cycle.
// - An OFF code read at the end of the boot hold shuts the block down until the enable is cycled.
module vidstp_top #(
    parameter int N_SAMPLE = vidstp_pkg::SAMPLES_PER_CYCLE
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [vidstp_pkg::CODE_W-1:0] VOLTAGE_ID_CODE,
    input wire logic ENABLE,
    input wire logic BOOT_DONE,
    input wire logic CYCLE_TICK,
    input wire logic SAMPLE_STB,
    output vidstp_pkg::vidstp_dac_t DAC,
    output logic SHUTDOWN,
    output logic REGULATING
);
    import vidstp_pkg::*;

    localparam logic [3:0] HALF_WAIT = 4'(N_SAMPLE / 2);

    typedef enum logic [2:0] {ST_DIS, ST_BOOT, ST_IDLE, ST_WAIT, ST_SLEW, ST_SHUT} vidstp_state_t;

    logic [CODE_W-1:0] vid_meta_q;
    logic [CODE_W-1:0] vid_q;
    vidstp_state_t state_q, state_d;
    vidstp_dac_t dac_q, dac_d;
    logic signed [8:0] saved_diff_q, saved_diff_d;
    logic [3:0] wait_cnt_q, wait_cnt_d;
    logic synced_q, synced_d;
    logic [CODE_W-1:0] tgt;
    logic signed [8:0] diff;
    logic [8:0] mag;
    logic [8:0] step_amt;
    logic [CODE_W-1:0] stepped;
    logic sample;

    // The code pins are asynchronous to CLK; bits may be caught mid-change.
    always_ff @(posedge CLK) begin
        if (RST) begin
            vid_meta_q <= '0;
            vid_q <= '0;
        end else begin
            vid_meta_q <= VOLTAGE_ID_CODE;
            vid_q <= vid_meta_q;
        end
    end

    always_comb begin
        // An OFF code during regulation is not a level; the DAC simply holds.
        tgt = vidstp_is_off(vid_q) ? dac_q.code : vidstp_target(vid_q);
        diff = $signed({1'b0, dac_q.code}) - $signed({1'b0, tgt});
        mag = (diff < 0) ? 9'(-diff) : 9'(diff);
        step_amt = (mag > STEP_CODES) ? STEP_CODES : mag;
        stepped = (diff > 0) ? dac_q.code - step_amt[7:0] : dac_q.code + step_amt[7:0];
        sample = SAMPLE_STB && synced_q;
    end

    always_comb begin
        state_d = state_q;
        dac_d = dac_q;
        saved_diff_d = saved_diff_q;
        wait_cnt_d = wait_cnt_q;
        synced_d = synced_q;
        if (!ENABLE) begin
            state_d = ST_DIS;
            dac_d.code = CODE_BOOT;
            synced_d = 1'b0;
            wait_cnt_d = '0;
        end else begin
            case (state_q)
                ST_DIS: begin
                    state_d = ST_BOOT;
                end
                ST_BOOT: begin
                    if (BOOT_DONE) begin
                        state_d = vidstp_is_off(vid_q) ? ST_SHUT : ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    // Samples start on a cycle boundary so the half wait is measured in whole strobes.
                    if (CYCLE_TICK) begin
                        synced_d = 1'b1;
                    end
                    if (sample && diff != 0) begin
                        if (mag > STEP_CODES) begin
                            dac_d.code = stepped;
                            state_d = ST_SLEW;
                        end else begin
                            saved_diff_d = diff;
                            wait_cnt_d = '0;
                            state_d = ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (sample) begin
                        if (diff != saved_diff_q) begin
                            state_d = ST_IDLE;
                        end else if (wait_cnt_q + 4'h1 >= HALF_WAIT) begin
                            dac_d.code = stepped;
                            state_d = ST_IDLE;
                        end else begin
                            wait_cnt_d = wait_cnt_q + 4'h1;
                        end
                    end
                end
                ST_SLEW: begin
                    if (sample) begin
                        if (diff == 0) begin
                            state_d = ST_IDLE;
                        end else begin
                            dac_d.code = stepped;
                        end
                    end
                end
                ST_SHUT: begin
                    state_d = ST_SHUT;
                end
                default: begin
                    state_d = ST_DIS;
                end
            endcase
        end
        dac_d.uv = vidstp_uv(dac_d.code);
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= ST_DIS;
            dac_q <= '{code: CODE_BOOT, uv: vidstp_uv(CODE_BOOT)};
            saved_diff_q <= '0;
            wait_cnt_q <= '0;
            synced_q <= 1'b0;
        end else begin
            state_q <= state_d;
            dac_q <= dac_d;
            saved_diff_q <= saved_diff_d;
            wait_cnt_q <= wait_cnt_d;
            synced_q <= synced_d;
        end
    end

    assign DAC = dac_q;
    assign SHUTDOWN = (state_q == ST_SHUT);
    assign REGULATING = (state_q == ST_IDLE) || (state_q == ST_WAIT) || (state_q == ST_SLEW);

    logic reg_now;
    assign reg_now = REGULATING && ENABLE;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_dac_range_ok: assert property (dac_q.code <= CODE_FLOOR)
        else $error("DAC code reached an OFF or unlisted code.");
    a_dac_uv_match: assert property (dac_q.uv == vidstp_uv(dac_q.code))
        else $error("DAC level disagrees with DAC code.");
    a_move_on_strobe: assert property ((reg_now && !sample) ##1 ENABLE |-> $stable(dac_q.code))
        else $error("DAC moved without a sample strobe.");
    a_step_bounded: assert property (reg_now ##1 ENABLE |->
        ((dac_q.code >= $past(dac_q.code)) ? (dac_q.code - $past(dac_q.code)) : ($past(dac_q.code) - dac_q.code))
        <= 8'(STEP_CODES))
        else $error("DAC moved by more than one step.");
    a_wait_then_step: assert property ((state_q == ST_IDLE && sample && diff != 0 && mag <= STEP_CODES && ENABLE)
        |=> (state_q == ST_WAIT && $stable(dac_q.code)))
        else $error("Small change did not enter the half-cycle wait.");
    a_wait_cancel: assert property ((state_q == ST_WAIT && sample && diff != saved_diff_q && ENABLE)
        |=> (state_q == ST_IDLE && $stable(dac_q.code)))
        else $error("Pending step not cancelled.");
    a_slew_step: assert property ((state_q == ST_SLEW && sample && diff > 0 && ENABLE)
        |=> dac_q.code == $past(dac_q.code) - 8'(STEP_CODES) || dac_q.code == $past(tgt))
        else $error("Slew did not take a full step.");
    a_boot_off: assert property ((state_q == ST_BOOT && BOOT_DONE && ENABLE && vidstp_is_off(vid_q))
        |=> SHUTDOWN ##1 (SHUTDOWN || !$past(ENABLE)))
        else $error("OFF code at boot did not shut down.");
    a_unsynced_hold: assert property ((state_q == ST_IDLE && !synced_q && ENABLE) |=> $stable(dac_q.code))
        else $error("DAC moved before the first cycle tick.");

    c_slew: cover property (state_q == ST_SLEW && sample && diff == 0);
    c_wait_done: cover property (state_q == ST_WAIT ##1 state_q == ST_IDLE && $changed(dac_q.code));
    c_cancel: cover property (state_q == ST_WAIT && sample && diff != saved_diff_q);
    c_shutdown: cover property ($rose(SHUTDOWN));
endmodule

//--- testbench/vidstp_cpu.sv
`timescale 1ns/10ps
// Processor side: moves its code one unit per switching cycle unless told to jump.
module vidstp_cpu (
    input wire logic clk,
    input wire logic tick,
    input wire logic jump,
    input wire logic [7:0] want,
    output logic [7:0] code
);
    initial code = 8'h52;
    always @(posedge clk) begin
        if (jump) begin
            code <= want;
        end else if (tick && code < want) begin
            code <= code + 8'h01;
        end else if (tick && code > want) begin
            code <= code - 8'h01;
        end
    end
endmodule

//--- testbench/voltage_id_dac_stepper_tb.sv
`timescale 1ns/10ps
module voltage_id_dac_stepper_tb;
    import vidstp_pkg::*;
    logic clk, rst, en, boot_done, tick, stb, jump, shut, reg_on, prev_on;
    logic [7:0] want, code, prev;
    logic [3:0] ph;
    vidstp_dac_t dac;
    int fail_count = 0;
    int checked = 0;
    int seed = 32'hC1F6;

    vidstp_top #(.N_SAMPLE(6)) DUT (.CLK(clk), .RST(rst), .VOLTAGE_ID_CODE(code), .ENABLE(en),
        .BOOT_DONE(boot_done), .CYCLE_TICK(tick), .SAMPLE_STB(stb), .DAC(dac), .SHUTDOWN(shut),
        .REGULATING(reg_on));
    vidstp_cpu CPU (.clk(clk), .tick(tick), .jump(jump), .want(want), .code(code));

    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end

    // Twelve clocks per switching cycle, so six strobes land one clock after each odd phase.
    always @(posedge clk) begin
        ph <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
        tick <= (ph == 4'hB);
        stb <= ph[0];
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (e !== g) begin
            fail_count++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic results();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Any move of the level while regulating must be no larger than one 12.5mV step.
    always @(posedge clk) begin
        if (reg_on && prev_on && dac.code !== prev) begin
            chk("step", 32'h1, 32'((dac.code - prev + 8'h02) <= 8'h04));
        end
        prev <= dac.code;
        prev_on <= reg_on;
    end

    task automatic boot(input logic [7:0] w, input logic off);
        en <= 1'b0;
        want <= w;
        jump <= 1'b1;
        repeat (3) @(posedge clk);
        chk("idle", 32'h52, 32'(dac.code));
        en <= 1'b1;
        repeat (2) @(posedge clk);
        boot_done <= 1'b1;
        @(posedge clk);
        boot_done <= 1'b0;
        repeat (2) @(posedge clk);
        chk("shut", 32'(off), 32'(shut));
        chk("reg", 32'(!off), 32'(reg_on));
    endtask

    // Codes past the lowest listed level settle at that level.
    function automatic logic [7:0] exp_code(input logic [7:0] w);
        return (w > CODE_FLOOR) ? CODE_FLOOR : w;
    endfunction

    task automatic go(input logic [7:0] w, input logic j, input int lim);
        logic [7:0] e;
        e = exp_code(w);
        want <= w;
        jump <= j;
        for (int i = 0; i < lim && dac.code !== e; i++) @(posedge clk);
        chk("code", 32'(e), 32'(dac.code));
        chk("uv", 32'(TOP_UV - int'(e) * LSB_UV), 32'(dac.uv));
    endtask

    initial begin
        rst = 1'b1;
        en = 1'b0;
        boot_done = 1'b0;
        want = 8'h52;
        jump = 1'b0;
        ph = 4'h0;
        tick = 1'b0;
        stb = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        boot(8'hFF, 1'b1);
        boot(8'hFE, 1'b1);
        boot(8'h40, 1'b0);
        go(8'h40, 1'b1, 200);
        go(8'h44, 1'b0, 200);
        go(8'h54, 1'b1, 30);
        go(8'h00, 1'b1, 300);
        go(8'hB5, 1'b1, 300);
        go(8'h60, 1'b1, 300);
        // A one-code change must sit through the half-cycle wait before the level moves.
        want <= 8'h61;
        repeat (4) @(posedge clk);
        chk("wait", 32'h60, 32'(dac.code));
        go(8'h61, 1'b1, 100);
        want <= 8'hFF;
        repeat (60) @(posedge clk);
        chk("hold", 32'h61, 32'(dac.code));
        chk("shut", 32'h0, 32'(shut));
        repeat (8) go(8'($unsigned($random(seed)) % 32'hB9), 1'($random(seed)), 3000);
        results();
    end

    // Eight random moves, each paced or a jump, across the full range fit well inside this span.
    initial begin
        #(20 * 40000);
        fail_count++;
        results();
    end
endmodule
